// ---- design/i2c_master_core.sv ----
/*
  single-master two-wire bus interface: control, status, clock setup and data
  registers behind an avalon-mm slave, plus the bit engine driving the pins.
  assumes open-drain pads resolved outside; pin inputs are asynchronous.
*/
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "i2c_master_regs.svh"
`default_nettype none
module i2c_master_core (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [2:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output var  logic [31:0]                readdata,
  output var  logic                       waitrequest,
  input  wire i2c_master_pkg::pins_in_s   pin_in,
  output var  i2c_master_pkg::pins_out_s  pin_out,
  output var  logic                       irq
);
  import i2c_master_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [1:0]  scl_sync_reg, sda_sync_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  ctl_s        ctl_reg;
  logic [7:0]  clk_setup_reg, data_reg, shift_reg;
  phase_e      state_reg;
  logic [1:0]  qph_reg;
  logic [3:0]  bit_reg;
  logic [11:0] qcnt_reg;
  logic        scl_low_reg, sda_low_reg, tx_mode_reg, nack_reg, irq_reg;
  logic        start_sent_reg, byte_done_reg, dir_reg, addr_evt_reg, ack_fail_reg;
  logic        start_sent_next, byte_done_next, dir_next, addr_evt_next, ack_fail_next;
  logic        event_reg, master_reg, armed_reg, tx_pend_reg, rx_pend_reg;
  logic        addr_next_reg, addr_byte_reg, rx_dir_reg;

  function automatic logic hit(input logic [2:0] idx);
    return address == idx;
  endfunction : hit

  function automatic logic [11:0] quarter_len(input logic [7:0] setup);
    logic [11:0] base;
    base = setup[`CCR_SPEED] ? 12'(`FAST_QUARTER_CYC) : 12'(`STD_QUARTER_CYC);
    return 12'(base + 12'(setup[6:0]) * 12'(`DIV_STEP_CYC));
  endfunction : quarter_len

  // level to drive low for a bit slot; slot 8 is the acknowledge
  function automatic logic drive_low(input logic tx, input logic [3:0] idx,
                                     input logic msb, input logic ack);
    if (idx == 4'd8) return tx ? 1'b0 : ack;
    return tx ? ~msb : 1'b0;
  endfunction : drive_low

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], pin_in.scl};
      sda_sync_reg <= {sda_sync_reg[0], pin_in.sda};
    end
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];

  // ----------------------------------------
  // bus slave: one wait cycle, then accept
  // ----------------------------------------
  assign waitrequest = (read | write) & ~ack_reg;
  wire rd_acc = read & ack_reg;
  wire wr_acc = write & ack_reg;
  wire [7:0] wbyte = writedata[7:0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) ack_reg <= 1'b0;
    else ack_reg <= (read | write) & ~ack_reg;
  end

  // read value is latched in the wait cycle and stands at the accept edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      unique case (address)
        `IDX_CONTROL:  readdata_reg <= {26'h0, ctl_reg.enable, 1'b0, ctl_reg.start,
                                        ctl_reg.ack_en, ctl_reg.stop, ctl_reg.irq_allow};
        `IDX_STATUS1:  readdata_reg <= {24'h0, event_reg, 1'b0, dir_reg, 1'b0,
                                        byte_done_reg, 1'b0, master_reg,
                                        start_sent_reg};
        `IDX_STATUS2:  readdata_reg <= {27'h0, ack_fail_reg, 4'h0};
        `IDX_CLKSETUP: readdata_reg <= {24'h0, clk_setup_reg};
        `IDX_DATA:     readdata_reg <= {24'h0, data_reg};
        default:       readdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign readdata = readdata_reg;

  // ----------------------------------------
  // bit engine strobes
  // ----------------------------------------
  wire active = (state_reg == ST_START) | (state_reg == ST_BIT) | (state_reg == ST_STOP);
  // slave holding scl low restarts the quarter count from its reload value
  wire stall = active & ~scl_low_reg & ~scl_s;
  wire tick = active & ~stall & (qcnt_reg == 12'h000);
  wire blk = start_sent_reg | byte_done_reg | addr_evt_reg;
  wire in_hold = (state_reg == ST_HOLD) & ~blk;
  wire go_stop = in_hold & ctl_reg.stop & master_reg;
  wire go_rst = in_hold & ~ctl_reg.stop & ctl_reg.start;
  wire load_tx = in_hold & ~ctl_reg.stop & ~ctl_reg.start & tx_pend_reg;
  wire load_rx = in_hold & ~ctl_reg.stop & ~ctl_reg.start & ~tx_pend_reg & rx_pend_reg;
  wire go_start = (state_reg == ST_IDLE) & ctl_reg.start & scl_s & sda_s;
  wire start_done = (state_reg == ST_START) & tick & (qph_reg == 2'd3);
  wire byte_end = (state_reg == ST_BIT) & tick & (qph_reg == 2'd3) & (bit_reg == 4'd8);
  wire stop_done = (state_reg == ST_STOP) & tick & (qph_reg == 2'd2);
  wire clr_drw = armed_reg & wr_acc & hit(`IDX_DATA);
  wire clr_drd = armed_reg & rd_acc & hit(`IDX_DATA);
  wire clr_crw = armed_reg & wr_acc & hit(`IDX_CONTROL);

  // ----------------------------------------
  // control, clock setup and data registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_reg <= ctl_s'(`RST_CONTROL);
    end else begin
      if (!ctl_reg.enable) begin
        ctl_reg.start     <= 1'b0;
        ctl_reg.ack_en    <= 1'b0;
        ctl_reg.irq_allow <= 1'b0;
      end
      if (start_done) ctl_reg.start <= 1'b0;
      if (stop_done) ctl_reg.stop <= 1'b0;
      if (wr_acc && hit(`IDX_CONTROL)) begin
        ctl_reg.enable <= wbyte[`CR_ENABLE];
        // first write while disabled only switches the unit on
        if (ctl_reg.enable) begin
          ctl_reg.start     <= wbyte[`CR_START];
          ctl_reg.ack_en    <= wbyte[`CR_ACK];
          ctl_reg.stop      <= wbyte[`CR_STOP];
          ctl_reg.irq_allow <= wbyte[`CR_IRQ];
        end
      end
    end
  end

  // setup is untouched by disable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) clk_setup_reg <= `RST_CLKSETUP;
    else if (wr_acc && hit(`IDX_CLKSETUP)) clk_setup_reg <= wbyte;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) data_reg <= `RST_DATA;
    else if (byte_end && !tx_mode_reg) data_reg <= shift_reg;
    else if (wr_acc && hit(`IDX_DATA)) data_reg <= wbyte;
  end

  // ----------------------------------------
  // quarter-period divider
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) qcnt_reg <= 12'h000;
    else if (!active || stall || tick) qcnt_reg <= quarter_len(clk_setup_reg);
    else qcnt_reg <= qcnt_reg - 12'h001;
  end

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      qph_reg     <= 2'd0;
      bit_reg     <= 4'd0;
      shift_reg   <= 8'h00;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      tx_mode_reg <= 1'b0;
      nack_reg    <= 1'b0;
    end else if (!ctl_reg.enable) begin
      state_reg   <= ST_IDLE;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          scl_low_reg <= 1'b0;
          sda_low_reg <= 1'b0;
          if (go_start) begin
            state_reg   <= ST_START;
            qph_reg     <= 2'd2;
            sda_low_reg <= 1'b1;
          end
        end
        ST_HOLD: begin
          // a lone ack failure lets go of the clock
          scl_low_reg <= blk | ~ack_fail_reg;
          if (go_stop) begin
            state_reg   <= ST_STOP;
            qph_reg     <= 2'd0;
            scl_low_reg <= 1'b1;
            // a released clock must fall first, else sda falling reads as a start
            sda_low_reg <= scl_low_reg;
          end else if (go_rst) begin
            state_reg   <= ST_START;
            qph_reg     <= 2'd0;
            scl_low_reg <= 1'b1;
            sda_low_reg <= 1'b0;
          end else if (load_tx || load_rx) begin
            state_reg   <= ST_BIT;
            qph_reg     <= 2'd0;
            bit_reg     <= 4'd0;
            tx_mode_reg <= load_tx;
            shift_reg   <= load_tx ? data_reg : 8'h00;
            scl_low_reg <= 1'b1;
            sda_low_reg <= drive_low(load_tx, 4'd0, data_reg[7], ctl_reg.ack_en);
          end
        end
        ST_START: begin
          if (tick) begin
            qph_reg <= qph_reg + 2'd1;
            unique case (qph_reg)
              2'd0: scl_low_reg <= 1'b0;
              2'd1: sda_low_reg <= 1'b1;
              2'd2: scl_low_reg <= 1'b1;
              2'd3: state_reg <= ST_HOLD;
            endcase
          end
        end
        ST_BIT: begin
          if (tick) begin
            qph_reg <= qph_reg + 2'd1;
            unique case (qph_reg)
              2'd0: scl_low_reg <= 1'b0;
              2'd1: begin
                if (bit_reg == 4'd8) nack_reg <= sda_s;
                else shift_reg <= {shift_reg[6:0], sda_s};
              end
              2'd2: scl_low_reg <= 1'b1;
              2'd3: begin
                if (bit_reg == 4'd8) begin
                  state_reg   <= ST_HOLD;
                  sda_low_reg <= 1'b0;
                end else begin
                  bit_reg     <= bit_reg + 4'd1;
                  sda_low_reg <= drive_low(tx_mode_reg, bit_reg + 4'd1, shift_reg[7],
                                           ctl_reg.ack_en);
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (qph_reg == 2'd0) sda_low_reg <= 1'b1;
          if (tick) begin
            qph_reg <= qph_reg + 2'd1;
            if (qph_reg == 2'd0) scl_low_reg <= 1'b0;
            if (qph_reg == 2'd1) sda_low_reg <= 1'b0;
            if (qph_reg == 2'd2) state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // status flags: clears first, sets last so a set wins
  // ----------------------------------------
  always_comb begin
    start_sent_next = start_sent_reg;
    byte_done_next  = byte_done_reg;
    dir_next        = dir_reg;
    addr_evt_next   = addr_evt_reg;
    ack_fail_next   = ack_fail_reg;
    if (clr_drw) start_sent_next = 1'b0;
    if (dir_reg ? clr_drw : clr_drd) begin
      byte_done_next = 1'b0;
      dir_next       = 1'b0;
    end
    if (clr_crw) addr_evt_next = 1'b0;
    // only a failure that software actually saw is cleared by the read
    if (rd_acc && hit(`IDX_STATUS2) && readdata_reg[`SR2_ACKFAIL]) ack_fail_next = 1'b0;
    if (start_done) start_sent_next = 1'b1;
    if (byte_end) begin
      if (tx_mode_reg && nack_reg) ack_fail_next = 1'b1;
      else if (tx_mode_reg && addr_byte_reg) addr_evt_next = 1'b1;
      else if (tx_mode_reg || ctl_reg.ack_en) begin
        byte_done_next = 1'b1;
        dir_next       = tx_mode_reg;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_sent_reg <= 1'b0;
      byte_done_reg  <= 1'b0;
      dir_reg        <= 1'b0;
      addr_evt_reg   <= 1'b0;
      ack_fail_reg   <= 1'b0;
      event_reg      <= 1'b0;
    end else begin
      start_sent_reg <= start_sent_next;
      byte_done_reg  <= byte_done_next;
      dir_reg        <= dir_next;
      addr_evt_reg   <= addr_evt_next;
      ack_fail_reg   <= ack_fail_next;
      event_reg      <= start_sent_next | byte_done_next | addr_evt_next
                        | ack_fail_next;
      // disable clears synchronously: the async branch stays constant-only
      if (!ctl_reg.enable) begin
        {start_sent_reg, byte_done_reg, dir_reg} <= 3'h0;
        {addr_evt_reg, ack_fail_reg, event_reg}  <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // mode and pending-transfer bookkeeping
  // ----------------------------------------
  wire dr_wr = wr_acc & hit(`IDX_DATA) & master_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_reg    <= 1'b0;
      armed_reg     <= 1'b0;
      tx_pend_reg   <= 1'b0;
      rx_pend_reg   <= 1'b0;
      addr_next_reg <= 1'b0;
      addr_byte_reg <= 1'b0;
      rx_dir_reg    <= 1'b0;
    end else begin
      if (rd_acc && hit(`IDX_STATUS1)) armed_reg <= 1'b1;
      else if ((rd_acc || wr_acc) && (hit(`IDX_DATA) || hit(`IDX_CONTROL))) armed_reg <= 1'b0;
      if (stop_done) master_reg <= 1'b0;
      else if (go_start) master_reg <= 1'b1;
      if (load_tx) tx_pend_reg <= 1'b0;
      if (dr_wr && (addr_next_reg || !rx_dir_reg)) begin
        tx_pend_reg   <= 1'b1;
        addr_byte_reg <= addr_next_reg;
        addr_next_reg <= 1'b0;
        if (addr_next_reg) rx_dir_reg <= wbyte[0];
      end
      if (start_done) addr_next_reg <= 1'b1;
      if (load_rx || stop_done || start_done) rx_pend_reg <= 1'b0;
      if ((clr_crw && addr_evt_reg && rx_dir_reg)
          || (rd_acc && hit(`IDX_DATA) && master_reg && rx_dir_reg && !addr_next_reg))
        rx_pend_reg <= 1'b1;
      if (!ctl_reg.enable) begin
        {master_reg, armed_reg, tx_pend_reg, rx_pend_reg} <= 4'h0;
        {addr_next_reg, addr_byte_reg, rx_dir_reg}        <= 3'h0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq_reg <= 1'b0;
    else irq_reg <= ctl_reg.irq_allow
                    & (byte_done_reg | start_sent_reg | ack_fail_reg);
  end

  assign irq = irq_reg;
  assign pin_out = '{scl_out: 1'b0, scl_oe: scl_low_reg, sda_out: 1'b0, sda_oe: sda_low_reg};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_event_follows: assert property ($rose(byte_done_reg) || $rose(start_sent_reg)
    || $rose(ack_fail_reg) || $rose(addr_evt_reg) |-> event_reg)
    else $error("event flag missing");
  a_disable_clears: assert property (!ctl_reg.enable |=> !event_reg && !byte_done_reg
    && !master_reg && !start_sent_reg && !ctl_reg.start && !pin_out.scl_oe)
    else $error("disable left state");
  a_sr1_reserved: assert property (rd_acc && hit(`IDX_STATUS1)
    |-> readdata[6] == 1'b0 && readdata[4] == 1'b0 && readdata[2] == 1'b0)
    else $error("reserved bit set");
  a_dir_only_done: assert property (dir_reg |-> byte_done_reg)
    else $error("direction without byte done");
  a_done_holds_scl: assert property (byte_done_reg || start_sent_reg |-> pin_out.scl_oe)
    else $error("clock not held");
  a_af_no_stretch: assert property (state_reg == ST_HOLD && ack_fail_reg && !blk
    && !go_stop && !go_rst ##1 state_reg == ST_HOLD |-> !pin_out.scl_oe)
    else $error("ack fail stretched clock");
  a_irq_on_start: assert property ($rose(start_sent_reg) && ctl_reg.irq_allow
    |=> irq) else $error("no interrupt");
  a_af_read_clr: assert property (rd_acc && hit(`IDX_STATUS2) && readdata[`SR2_ACKFAIL]
    && !byte_end |=> !ack_fail_reg) else $error("ack fail not cleared");
  a_master_set: assert property ($rose(master_reg) |-> state_reg == ST_START)
    else $error("master without start");
  a_setup_kept: assert property (!(wr_acc && hit(`IDX_CLKSETUP)) |=> $stable(clk_setup_reg))
    else $error("setup changed");
  a_stop_ends: assert property (stop_done |=> !master_reg && state_reg == ST_IDLE)
    else $error("stop did not end");

  c_start: cover property (start_done);
  c_tx_byte: cover property (byte_end && tx_mode_reg && !nack_reg && !addr_byte_reg);
  c_rx_byte: cover property (byte_end && !tx_mode_reg);
  c_stop: cover property (stop_done);
endmodule : i2c_master_core
`default_nettype wire

// ---- include/i2c_master_regs.svh ----
/*
  register indices, field positions, reset values and timing counts of the
  two-wire bus master. assumes a 250 MHz mclk and word-indexed bus access.
*/
`ifndef I2C_MASTER_REGS_SVH
`define I2C_MASTER_REGS_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CONTROL   3'h0
`define IDX_STATUS1   3'h1
`define IDX_STATUS2   3'h2
`define IDX_CLKSETUP  3'h3
`define IDX_DATA      3'h6
// ----------------------------------------
// field positions
// ----------------------------------------
`define CR_ENABLE     5
`define CR_START      3
`define CR_ACK        2
`define CR_STOP       1
`define CR_IRQ        0
`define SR1_EVENT     7
`define SR1_DIR       5
`define SR1_DONE      3
`define SR1_MASTER    1
`define SR1_STARTED   0
`define SR2_ACKFAIL   4
`define CCR_SPEED     7
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CONTROL   8'h00
`define RST_CLKSETUP  8'h00
`define RST_DATA      8'h00
// ----------------------------------------
// timing: quarter of a bus clock period
// ----------------------------------------
`define MCLK_MHZ         250
`define STD_QUARTER_NS   2500
`define FAST_QUARTER_NS  625
`define STD_QUARTER_CYC  ((`STD_QUARTER_NS * `MCLK_MHZ) / 1000)
`define FAST_QUARTER_CYC ((`FAST_QUARTER_NS * `MCLK_MHZ) / 1000)
`define DIV_STEP_CYC     4
`endif

// ---- include/i2c_master_pkg.sv ----
/*
  types of the two-wire bus master: phases, control fields, pin groups.
  assumes nothing of its surroundings.
*/
package i2c_master_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_HOLD, ST_BIT, ST_STOP} phase_e;
  typedef struct packed {
    logic enable;
    logic start;
    logic ack_en;
    logic stop;
    logic irq_allow;
  } ctl_s;
  typedef struct packed {
    logic scl;
    logic sda;
  } pins_in_s;
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } pins_out_s;
endpackage : i2c_master_pkg

// ---- verif/bus_slave_model.sv ----
/*
  behavioural slave on the two-wire bus: acks its address and written bytes,
  answers reads from tx_byte. assumes pull-ups resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  input  wire logic [7:0] tx_byte,
  output var  logic       sda_oe,
  output var  logic [7:0] rx_byte
);
  logic       active  = 1'b0;
  logic       addr_ph = 1'b0;
  logic       rd_mode = 1'b0;
  logic [3:0] bitn    = 4'h0;
  logic [7:0] sh      = 8'h00;
  logic [7:0] sh_out  = 8'hff;
  initial sda_oe = 1'b0;
  initial rx_byte = 8'h00;
  // -----------------
  // framing
  // -----------------
  always @(negedge sda) if (scl === 1'b1) begin
    active  = 1'b1;
    addr_ph = 1'b1;
    rd_mode = 1'b0;
    bitn    = 4'h0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    sda_oe = 1'b0;
  end
  // -----------------
  // bits, msb first
  // -----------------
  always @(posedge scl) if (active) begin
    if (bitn < 4'h8) sh = {sh[6:0], sda};
    else if (rd_mode && !addr_ph && sda) active = 1'b0;
    bitn = bitn + 4'h1;
  end
  // only changes sda while scl is low, so never fakes a start or stop
  always @(negedge scl) if (active) begin
    if (bitn == 4'h9) begin
      bitn    = 4'h0;
      addr_ph = 1'b0;
      sh_out  = tx_byte;
    end
    if (bitn == 4'h8) begin
      if (addr_ph) rd_mode = sh[0];
      else if (!rd_mode) rx_byte = sh;
      sda_oe = (addr_ph || !rd_mode) && !nack;
    end else
      sda_oe = rd_mode && !addr_ph && !sh_out[3'h7 - bitn[2:0]];
  end
endmodule : bus_slave_model
`default_nettype wire

// ---- verif/i2c_master_status_clock_data_tb.sv ----
/*
  self-checking bench: avalon-mm register tasks and bus transfers.
  assumes the core, its package and the slave model are compiled first.
*/
`timescale 1ns/1ps
`include "i2c_master_regs.svh"
`default_nettype none
module i2c_master_status_clock_data_tb;
  import i2c_master_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  address = 3'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  pins_in_s    pin_in;
  pins_out_s   pin_out;
  logic        slave_sda_oe;
  logic        nack = 1'b0;
  logic [7:0]  tx_byte = 8'hc3;
  logic [7:0]  rx_byte;
  logic [7:0]  rd;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          irq_wait = 0;
  // standard quarter with divider 5, from the bus timing constants
  localparam int std_quarter = `STD_QUARTER_CYC + 5 * `DIV_STEP_CYC;
  always #2 mclk = ~mclk;
  assign pin_in = '{scl: ~pin_out.scl_oe, sda: ~(pin_out.sda_oe | slave_sda_oe)};
  i2c_master_core DUT (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
  bus_slave_model slave (.scl(pin_in.scl), .sda(pin_in.sda), .nack(nack),
    .tx_byte(tx_byte), .sda_oe(slave_sda_oe), .rx_byte(rx_byte));
  // -----------------
  // tasks
  // -----------------
  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    write <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    d = readdata[7:0];
    read <= 1'b0;
  endtask : bus_rd
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    bus_rd(a, rd);
    chk(rd, exp);
  endtask : rd_chk
  // irq is registered, so let a stale level drop first
  task automatic wait_irq;
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    irq_wait = n;
    chk({7'h0, irq}, 8'h01);
  endtask : wait_irq
  task automatic poll(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      bus_rd(`IDX_STATUS1, rd);
      n++;
    end while (rd !== exp && n < 8000);
    chk(rd, exp);
  endtask : poll
  // -----------------
  // timeout
  // -----------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      print_verdict;
    end
  end
  // -----------------
  // sequence
  // -----------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(`IDX_CONTROL, 8'h00);
    rd_chk(`IDX_STATUS1, 8'h00);
    rd_chk(`IDX_STATUS2, 8'h00);
    rd_chk(`IDX_CLKSETUP, 8'h00);
    rd_chk(`IDX_DATA, 8'h00);
    rd_chk(3'h7, 8'h00); // unmapped
    bus_wr(`IDX_CLKSETUP, 8'h85); // fast, divider 5
    bus_wr(`IDX_CONTROL, 8'h21);
    rd_chk(`IDX_CONTROL, 8'h20); // first write sets enable only
    bus_wr(`IDX_CONTROL, 8'h29);
    wait_irq;
    rd_chk(`IDX_STATUS1, 8'h83);
    chk({7'h0, pin_out.scl_oe}, 8'h01);
    bus_wr(`IDX_DATA, 8'ha0);
    poll(8'h82); // address acked
    bus_wr(`IDX_CONTROL, 8'h21);
    bus_wr(`IDX_DATA, 8'h5a);
    wait_irq;
    rd_chk(`IDX_STATUS1, 8'haa);
    chk({7'h0, pin_out.scl_oe}, 8'h01);
    chk(rx_byte, 8'h5a);
    nack <= 1'b1;
    bus_wr(`IDX_DATA, 8'h3c);
    wait_irq;
    rd_chk(`IDX_STATUS1, 8'h82);
    repeat (200) @(posedge mclk);
    chk({7'h0, pin_out.scl_oe}, 8'h00);
    rd_chk(`IDX_STATUS2, 8'h10);
    rd_chk(`IDX_STATUS2, 8'h00);
    nack <= 1'b0;
    bus_wr(`IDX_CONTROL, 8'h23);
    poll(8'h00);
    chk({6'h0, pin_out.scl_oe, pin_out.sda_oe}, 8'h00);
    bus_wr(`IDX_CONTROL, 8'h29);
    wait_irq;
    rd_chk(`IDX_STATUS1, 8'h83); // arms the address write
    bus_wr(`IDX_DATA, 8'ha1); // read direction
    poll(8'h82);
    tx_byte <= 8'hff;
    bus_wr(`IDX_CONTROL, 8'h25);
    wait_irq; // acked first byte
    bus_wr(`IDX_CONTROL, 8'h27); // stop before last read
    rd_chk(`IDX_STATUS1, 8'h8a);
    rd_chk(`IDX_DATA, 8'hc3);
    poll(8'h00);
    bus_wr(`IDX_CONTROL, 8'h29);
    wait_irq;
    bus_wr(`IDX_CONTROL, 8'h00); // disable mid-flight
    repeat (2) @(posedge mclk);
    rd_chk(`IDX_STATUS1, 8'h00);
    chk({5'h0, irq, pin_out.scl_oe, pin_out.sda_oe}, 8'h00);
    rd_chk(`IDX_CLKSETUP, 8'h85);
    bus_wr(`IDX_CLKSETUP, 8'h05); // standard, divider 5
    bus_wr(`IDX_CONTROL, 8'h21);
    bus_wr(`IDX_CONTROL, 8'h29);
    wait_irq;
    // a start spans two standard quarters; fast timing would be far shorter
    chk({7'h0, irq_wait > 2 * std_quarter && irq_wait < 2 * std_quarter + 16}, 8'h01);
    print_verdict;
  end
endmodule : i2c_master_status_clock_data_tb
`default_nettype wire
